// [dv/line_unit_model.sv]
// Line interface unit and telecom bus source model for three channels
`default_nettype none
module line_unit_model (
    // Core clock, paces alarm pulses
    input  wire logic                                 core_clk,
    // Pins toward the device
    output var  logic [pin_mux_pkg::CHANNELS-1:0]     line_clk,
    output var  logic [pin_mux_pkg::CHANNELS-1:0]     neg_pin,
    output var  logic [pin_mux_pkg::CHANNELS-1:0]     pos_pin
);
    timeunit 1ns;
    timeprecision 100ps;

    // Clocks stand still low outside a bit
    initial begin
        line_clk = '0;
        neg_pin  = '0;
        pos_pin  = '0;
    end

    // One 1237 ns bit; rails held round both edges
    task automatic send_bit(input int ch, input logic p, input logic n, input logic hold_neg);
        #37;
        pos_pin[ch] = p;
        neg_pin[ch] = n;
        #400 line_clk[ch] = 1'b1;
        #400 line_clk[ch] = 1'b0;
        // Released rails float: show the inverse, not the last value
        #400 pos_pin[ch] = ~p;
        if (!hold_neg) begin
            neg_pin[ch] = ~n;
        end
    endtask

    // Board tie to ground before the pin turns into the alarm
    task automatic quiet(input int ch);
        neg_pin[ch] = 1'b0;
    endtask

    // Alarm pulse beside a path AIS frame on the bus
    task automatic alarm(input int ch, input int len);
        @(posedge core_clk);
        neg_pin[ch] <= 1'b1;
        repeat (len) @(posedge core_clk);
        neg_pin[ch] <= 1'b0;
    endtask
endmodule
`default_nettype wire

// [dv/tb_rx_neg_rail_lcv_alarm_pin_mux.sv]
// Self-checking bench for the shared alarm / violation / negative-rail pin mux
`default_nettype none
module tb_rx_neg_rail_lcv_alarm_pin_mux;
    timeunit 1ns;
    timeprecision 100ps;
    import pin_mux_pkg::*;

    logic                core_clk = 1'b0;
    logic                arst_n = 1'b0;
    logic [ADDR_W-1:0]   reg_addr = '0;
    logic [DATA_W-1:0]   reg_wdata = '0;
    logic                reg_wr = 1'b0;
    logic                reg_rd = 1'b0;
    logic [DATA_W-1:0]   reg_rdata;
    logic [CHANNELS-1:0] lclk, neg, pos, pdat, ndat, vld, ais;
    logic                irq;
    logic [15:0]         d;
    logic [5:0]          stat = '0;
    int                  cnt[3], nv[3], seen_v[3];
    int                  num_errors = 0;
    int                  compares = 0;

    always #50 core_clk = ~core_clk;

    rx_neg_rail_lcv_alarm_pin_mux u_dut (
        .core_clk(core_clk), .arst_n(arst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .rx_line_clock_in(lclk), .rx_negative_rail_in(neg), .rx_positive_rail_in(pos),
        .rx_pos_data(pdat), .rx_neg_data(ndat), .rx_data_valid(vld),
        .path_ais_defect(ais), .irq(irq));

    line_unit_model u_lu (.core_clk(core_clk), .line_clk(lclk), .neg_pin(neg), .pos_pin(pos));

    // Count valid pulses per channel
    always @(posedge core_clk) begin
        for (int i = 0; i < 3; i++) begin
            if (vld[i] === 1'b1) seen_v[i]++;
        end
    end

    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s exp %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [15:0] v);
        @(posedge core_clk);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_wr    <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask

    // Data stand only in the cycle after the strobe
    task automatic rd(input logic [ADDR_W-1:0] a);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask

    // Line mode run; STS-1 runs drive random pin levels to prove they are ignored
    task automatic run_line(input int ch, input int m, input int e);
        logic p, n;
        wr(CTRL_OFS[ch], 16'(m * 2 + e * 8));
        for (int b = 0; b < 6; b++) begin
            p = 1'($urandom);
            n = 1'($urandom);
            u_lu.send_bit(ch, p, n, 1'b0);
            nv[ch]++;
            if (m == MODE_SINGLE && n) begin
                cnt[ch]++;
                stat[STAT_LCV_LSB + ch] = 1'b1;
            end
        end
        repeat (6) @(posedge core_clk);
        #1 chk("valid count", 16'(seen_v[ch]), 16'(nv[ch]));
        chk("pos data", 16'(pdat[ch]), 16'(p));
        chk("neg data", 16'(ndat[ch]), 16'(m == MODE_DUAL && n));
        // Live word mirrors the held rails of this channel
        rd(LIVE_OFS);
        chk("live pos", 16'(d[LIVE_POS_LSB + ch]), 16'(p));
        chk("live neg", 16'(d[LIVE_NEG_LSB + ch]), 16'(m == MODE_DUAL && n));
        rd(CNT_OFS[ch]);
        chk("counter", d, 16'(cnt[ch]));
        cnt[ch] = 0;
        rd(INT_STATUS_OFS);
        chk("status", d, 16'(stat));
        chk("irq", 16'(irq), 16'(stat != 0));
        wr(INT_STATUS_OFS, 16'(stat));
        stat = '0;
    endtask

    // Bus on: a line bit is sent but ignored, alarm raises the defect
    task automatic run_bus(input int ch);
        u_lu.quiet(ch);
        wr(CTRL_OFS[ch], 16'(2 * ($urandom % 3) + 1));
        wr(INT_MASK_OFS, 16'h0000);
        u_lu.send_bit(ch, 1'($urandom), 1'b0, 1'b1);
        repeat (6) @(posedge core_clk);
        #1 chk("bus valid", 16'(seen_v[ch]), 16'(nv[ch]));
        rd(CNT_OFS[ch]);
        chk("bus count", d, 16'h0000);
        fork
            u_lu.alarm(ch, 8);
            begin
                repeat (6) @(posedge core_clk);
                #1 chk("defect on", 16'(ais[ch]), 16'h0001);
            end
        join
        repeat (6) @(posedge core_clk);
        #1 chk("defect off", 16'(ais), 16'h0000);
        stat[STAT_AIS_LSB + ch] = 1'b1;
        rd(INT_STATUS_OFS);
        chk("ais status", d, 16'(stat));
        chk("masked irq", 16'(irq), 16'h0000);
        wr(INT_MASK_OFS, 16'h003f);
        repeat (2) @(posedge core_clk);
        #1 chk("irq", 16'(irq), 16'h0001);
        wr(INT_STATUS_OFS, 16'(stat));
        stat = '0;
        repeat (2) @(posedge core_clk);
        #1 chk("irq clear", 16'(irq), 16'h0000);
        wr(CTRL_OFS[ch], 16'h0000);
    endtask

    task automatic stop_test;
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Watchdog, several times the expected run
    initial begin
        #1_000_000;
        num_errors++;
        stop_test();
    end

    initial begin
        void'($urandom(32'h1db7ca06));
        repeat (10) @(posedge core_clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        // Reset values, unmapped word last
        for (int a = 0; a < 10; a++) begin
            rd(a == 9 ? 4'hf : 4'(a));
            chk("reset reg", d, 16'h0000);
        end
        wr(INT_MASK_OFS, 16'h003f);
        for (int ch = 0; ch < 3; ch++) begin
            // Mode code 3 is unused and must behave as STS-1
            for (int m = 0; m < 4; m++) begin
                for (int e = 0; e < 2; e++) run_line(ch, m, e);
            end
            run_bus(ch);
        end
        stop_test();
    end
endmodule
`default_nettype wire

// [inc/pin_mux_pkg.sv]
// Constants and types shared by the negative-rail / violation / alarm pin mux
`default_nettype none
// Contract
// - Each channel uses the pin as the bus alarm input when its transmit bus is on, else as the line input its mode selects.
// - An alarm pulse makes the device declare the path AIS defect for that channel at once.
// - In single-rail mode the pin is the line code violation input, sampled on the chosen edge of the line clock.
// - In single-rail mode each sampled violation bumps that channel's violation / excess-zeros counter; the code stops the counter at CNT_MAX.
package pin_mux_pkg;
    // Sizes
    localparam int CHANNELS = 3;
    localparam int ADDR_W   = 4;
    localparam int DATA_W   = 16;
    localparam int CNT_W    = 16;
    localparam int STAT_W   = 6;

    // Core clock period, for reference by timing users
    localparam int CORE_CLK_PERIOD_NS = 100;

    // Register offsets (word index on the plain register port)
    localparam logic [CHANNELS-1:0][ADDR_W-1:0] CTRL_OFS = {4'h2, 4'h1, 4'h0};
    localparam logic [ADDR_W-1:0] INT_STATUS_OFS = 4'h3;
    localparam logic [ADDR_W-1:0] INT_MASK_OFS   = 4'h4;
    localparam logic [CHANNELS-1:0][ADDR_W-1:0] CNT_OFS = {4'h7, 4'h6, 4'h5};
    localparam logic [ADDR_W-1:0] LIVE_OFS       = 4'h8;

    // Control register fields
    localparam int CFG_BUS_EN_BIT = 0;
    localparam int CFG_MODE_LSB   = 1;
    localparam int CFG_EDGE_BIT   = 3;

    // Status / mask fields
    localparam int STAT_AIS_LSB = 0;
    localparam int STAT_LCV_LSB = 3;

    // Live register fields
    localparam int LIVE_AIS_LSB = 0;
    localparam int LIVE_POS_LSB = 4;
    localparam int LIVE_NEG_LSB = 8;

    // Values after reset, and the counter ceiling
    localparam logic              BUS_EN_RST = 1'b0;
    localparam logic [1:0]        MODE_RST   = 2'h0;
    localparam logic              EDGE_RST   = 1'b0;
    localparam logic [STAT_W-1:0] MASK_RST   = 6'h00;
    localparam logic [CNT_W-1:0]  CNT_MAX    = 16'hffff;

    // Reset release depth
    localparam int RST_SYNC_STAGES = 2;

    // Channel line modes
    typedef enum logic [1:0] {
        MODE_STS1   = 2'b00,
        MODE_SINGLE = 2'b01,
        MODE_DUAL   = 2'b10
    } mode_type;
endpackage
`default_nettype wire

// [src/line_edge_sampler.sv]
// Per-channel synchroniser and line clock edge sampler
`default_nettype none
module line_edge_sampler (
    // Core clock and reset
    input  wire logic core_clk,
    input  wire logic rst_n,
    // Line side pins
    input  wire logic line_clk_in,
    input  wire logic neg_pin_in,
    input  wire logic pos_pin_in,
    // Configuration
    input  wire logic fall_edge,
    // Sampled results
    output logic      strobe,
    output logic      neg_val,
    output logic      pos_val,
    output logic      neg_level
);
    import pin_mux_pkg::*;

    typedef struct packed {
        logic clk_s1;
        logic clk_s2;
        logic clk_s3;
        logic neg_s1;
        logic neg_s2;
        logic pos_s1;
        logic pos_s2;
        logic strobe;
        logic neg_val;
        logic pos_val;
    } smp_state_type;

    smp_state_type q;
    smp_state_type d;
    logic          edge_seen;

    // Data and clock share the same sync depth, so their alignment holds
    always_comb begin
        d = q;
        d.clk_s1 = line_clk_in;
        d.clk_s2 = q.clk_s1;
        d.clk_s3 = q.clk_s2;
        d.neg_s1 = neg_pin_in;
        d.neg_s2 = q.neg_s1;
        d.pos_s1 = pos_pin_in;
        d.pos_s2 = q.pos_s1;
        edge_seen = fall_edge ? (q.clk_s3 & ~q.clk_s2) : (q.clk_s2 & ~q.clk_s3);
        d.strobe = edge_seen;
        if (edge_seen) begin
            d.neg_val = q.neg_s2;
            d.pos_val = q.pos_s2;
        end
    end

    // State register
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // Results
    assign strobe    = q.strobe;
    assign neg_val   = q.neg_val;
    assign pos_val   = q.pos_val;
    assign neg_level = q.neg_s2;
endmodule
`default_nettype wire

// [src/rx_neg_rail_lcv_alarm_pin_mux.sv]
// Three-channel mux for the shared alarm / negative-rail / violation pin
//
// The address map and the plain strobed port were left to the implementer.
`default_nettype none
module rx_neg_rail_lcv_alarm_pin_mux (
    // Clock and reset
    input  wire logic                                core_clk,
    input  wire logic                                arst_n,
    // Register port
    input  wire logic [pin_mux_pkg::ADDR_W-1:0]      reg_addr,
    input  wire logic [pin_mux_pkg::DATA_W-1:0]      reg_wdata,
    input  wire logic                                reg_wr,
    input  wire logic                                reg_rd,
    output logic      [pin_mux_pkg::DATA_W-1:0]      reg_rdata,
    // Line side pins, one per channel
    input  wire logic [pin_mux_pkg::CHANNELS-1:0]    rx_line_clock_in,
    input  wire logic [pin_mux_pkg::CHANNELS-1:0]    rx_negative_rail_in,
    input  wire logic [pin_mux_pkg::CHANNELS-1:0]    rx_positive_rail_in,
    // Recovered line data toward the framers
    output logic      [pin_mux_pkg::CHANNELS-1:0]    rx_pos_data,
    output logic      [pin_mux_pkg::CHANNELS-1:0]    rx_neg_data,
    output logic      [pin_mux_pkg::CHANNELS-1:0]    rx_data_valid,
    // Defects and interrupt
    output logic      [pin_mux_pkg::CHANNELS-1:0]    path_ais_defect,
    output logic                                     irq
);
    import pin_mux_pkg::*;

    typedef struct packed {
        logic [CHANNELS-1:0]            bus_en;
        logic [CHANNELS-1:0][1:0]       mode;
        logic [CHANNELS-1:0]            fall_edge;
        logic [STAT_W-1:0]              int_status;
        logic [STAT_W-1:0]              int_mask;
        logic [CHANNELS-1:0][CNT_W-1:0] count;
        logic [CHANNELS-1:0]            alarm_prev;
        logic [CHANNELS-1:0]            ais_defect;
        logic [CHANNELS-1:0]            pos_data;
        logic [CHANNELS-1:0]            neg_data;
        logic [CHANNELS-1:0]            valid;
        logic [DATA_W-1:0]              rd_data;
        logic                           irq;
    } mux_state_type;

    mux_state_type                  q;
    mux_state_type                  d;
    logic [RST_SYNC_STAGES-1:0]     rst_pipe_q;
    logic                           rst_n;
    logic [CHANNELS-1:0]            smp_strobe;
    logic [CHANNELS-1:0]            smp_neg;
    logic [CHANNELS-1:0]            smp_pos;
    logic [CHANNELS-1:0]            alarm_lvl;
    logic [CHANNELS-1:0]            alarm_rise;
    logic [CHANNELS-1:0]            lcv_hit;
    logic [CHANNELS-1:0]            cnt_rd;
    logic [STAT_W-1:0]              ev_set;
    logic [STAT_W-1:0]              ev_clr;
    logic [CNT_W-1:0]               cnt_next;

    // Reset release through two flops; assertion stays asynchronous
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_pipe_q <= '0;
        end else begin
            rst_pipe_q <= {rst_pipe_q[RST_SYNC_STAGES-2:0], 1'b1};
        end
    end
    assign rst_n = rst_pipe_q[RST_SYNC_STAGES-1];

    // One sampler per channel; the pin is synchronised regardless of its role
    for (genvar g = 0; g < CHANNELS; g++) begin : g_smp
        line_edge_sampler u_smp (
            .core_clk    (core_clk),
            .rst_n       (rst_n),
            .line_clk_in (rx_line_clock_in[g]),
            .neg_pin_in  (rx_negative_rail_in[g]),
            .pos_pin_in  (rx_positive_rail_in[g]),
            .fall_edge   (q.fall_edge[g]),
            .strobe      (smp_strobe[g]),
            .neg_val     (smp_neg[g]),
            .pos_val     (smp_pos[g]),
            .neg_level   (alarm_lvl[g])
        );
    end

    // Next-state logic: pin roles, counters, registers, interrupt
    always_comb begin
        d = q;
        alarm_rise = '0;
        lcv_hit = '0;
        cnt_rd = '0;
        ev_set = '0;
        cnt_next = '0;
        ev_clr = (reg_wr && reg_addr == INT_STATUS_OFS) ? reg_wdata[STAT_W-1:0] : '0;

        for (int ch = 0; ch < CHANNELS; ch++) begin
            // Alarm role only while the transmit bus is on
            d.alarm_prev[ch] = alarm_lvl[ch];
            if (q.bus_en[ch]) begin
                alarm_rise[ch] = alarm_lvl[ch] & ~q.alarm_prev[ch];
                d.ais_defect[ch] = alarm_lvl[ch];
                d.valid[ch] = 1'b0;
            end else begin
                d.ais_defect[ch] = 1'b0;
                d.valid[ch] = smp_strobe[ch];
                // Positive rail is sampled in every line mode
                if (smp_strobe[ch]) begin
                    d.pos_data[ch] = smp_pos[ch];
                end
                case (q.mode[ch])
                    MODE_SINGLE: begin
                        lcv_hit[ch] = smp_strobe[ch] & smp_neg[ch];
                        d.neg_data[ch] = 1'b0;
                    end
                    MODE_DUAL: begin
                        if (smp_strobe[ch]) begin
                            d.neg_data[ch] = smp_neg[ch];
                        end
                    end
                    MODE_STS1: begin
                        // Pin is grounded on the board; its level is never used
                        d.neg_data[ch] = 1'b0;
                    end
                    default: begin
                        // Unused code behaves as STS-1: pin ignored
                        d.neg_data[ch] = 1'b0;
                    end
                endcase
            end
            ev_set[STAT_AIS_LSB + ch] = alarm_rise[ch];
            ev_set[STAT_LCV_LSB + ch] = lcv_hit[ch];

            // Counter clears on read; a hit in the same cycle still counts
            cnt_rd[ch] = reg_rd && reg_addr == CNT_OFS[ch];
            cnt_next = cnt_rd[ch] ? '0 : q.count[ch];
            if (lcv_hit[ch] && cnt_next != CNT_MAX) begin
                cnt_next = cnt_next + 16'h0001;
            end
            d.count[ch] = cnt_next;

            // Channel control write
            if (reg_wr && reg_addr == CTRL_OFS[ch]) begin
                d.bus_en[ch] = reg_wdata[CFG_BUS_EN_BIT];
                d.mode[ch] = reg_wdata[CFG_MODE_LSB +: 2];
                d.fall_edge[ch] = reg_wdata[CFG_EDGE_BIT];
            end
        end

        // Sticky status: a new event wins over a write-one clear
        d.int_status = (q.int_status & ~ev_clr) | ev_set;
        if (reg_wr && reg_addr == INT_MASK_OFS) begin
            d.int_mask = reg_wdata[STAT_W-1:0];
        end

        // Read data stands for one cycle only; unmapped reads give zero
        d.rd_data = '0;
        if (reg_rd) begin
            for (int ch = 0; ch < CHANNELS; ch++) begin
                if (reg_addr == CTRL_OFS[ch]) begin
                    d.rd_data[CFG_BUS_EN_BIT] = q.bus_en[ch];
                    d.rd_data[CFG_MODE_LSB +: 2] = q.mode[ch];
                    d.rd_data[CFG_EDGE_BIT] = q.fall_edge[ch];
                end
                if (cnt_rd[ch]) begin
                    d.rd_data = q.count[ch];
                end
            end
            if (reg_addr == INT_STATUS_OFS) begin
                d.rd_data[STAT_W-1:0] = q.int_status;
            end
            if (reg_addr == INT_MASK_OFS) begin
                d.rd_data[STAT_W-1:0] = q.int_mask;
            end
            if (reg_addr == LIVE_OFS) begin
                d.rd_data[LIVE_AIS_LSB +: CHANNELS] = q.ais_defect;
                d.rd_data[LIVE_POS_LSB +: CHANNELS] = q.pos_data;
                d.rd_data[LIVE_NEG_LSB +: CHANNELS] = q.neg_data;
            end
        end

        // Level interrupt from the next state, so it tracks status without lag
        d.irq = |(d.int_status & d.int_mask);
    end

    // State register
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
            q.bus_en <= {CHANNELS{BUS_EN_RST}};
            q.mode <= {CHANNELS{MODE_RST}};
            q.fall_edge <= {CHANNELS{EDGE_RST}};
            q.int_mask <= MASK_RST;
        end else begin
            q <= d;
        end
    end

    // Outputs, all straight from flops
    assign reg_rdata       = q.rd_data;
    assign rx_pos_data     = q.pos_data;
    assign rx_neg_data     = q.neg_data;
    assign rx_data_valid   = q.valid;
    assign path_ais_defect = q.ais_defect;
    assign irq             = q.irq;

    // Per-channel checks
    for (genvar g = 0; g < CHANNELS; g++) begin : g_chk
        chk_alarm_sets_ais: assert property (
            @(posedge core_clk) disable iff (!rst_n)
            (q.bus_en[g] && alarm_lvl[g] && !q.alarm_prev[g])
            |=> (q.int_status[STAT_AIS_LSB + g] && q.ais_defect[g]))
            else $error("alarm pulse did not declare path AIS");

        chk_bus_blocks_count: assert property (
            @(posedge core_clk) disable iff (!rst_n)
            (q.bus_en[g] && !cnt_rd[g]) |=> ($stable(q.count[g]) && !q.valid[g]))
            else $error("line input used while transmit bus enabled");

        chk_lcv_counts_up: assert property (
            @(posedge core_clk) disable iff (!rst_n)
            (!q.bus_en[g] && q.mode[g] == MODE_SINGLE && smp_strobe[g] && smp_neg[g]
                && q.count[g] != CNT_MAX && !cnt_rd[g])
            |=> q.count[g] == $past(q.count[g]) + 16'h0001)
            else $error("violation sample not counted");

        chk_lcv_sets_event: assert property (
            @(posedge core_clk) disable iff (!rst_n)
            (!q.bus_en[g] && q.mode[g] == MODE_SINGLE && smp_strobe[g] && smp_neg[g])
            |=> q.int_status[STAT_LCV_LSB + g])
            else $error("violation sample lost from status");

        chk_sts1_ignored: assert property (
            @(posedge core_clk) disable iff (!rst_n)
            (!q.bus_en[g] && q.mode[g] == MODE_STS1 && !cnt_rd[g]
                && !q.int_status[STAT_LCV_LSB + g])
            |=> ($stable(q.count[g]) && !q.int_status[STAT_LCV_LSB + g]
                && !q.ais_defect[g]))
            else $error("pin level used in STS-1 mode");
    end
endmodule
`default_nettype wire
